/* File: logic/id_page_slave.sv */
`timescale 1ns/1ps
module id_page_slave
  import id_page_pkg::*;
#(
  parameter int program_cycles = prog_cycles
)(
  input wire logic i_clk,             // System clock 40 MHz
  input wire logic i_nrst,            // Async reset, active low
  input wire logic i_cs_n,            // Chip select pin, low active
  input wire logic i_sclk,            // Serial clock pin
  input wire logic i_mosi,            // Serial data in pin
  input wire logic i_block_protect_hi,   // Nonvolatile protect bit 1
  input wire logic i_block_protect_lo,   // Nonvolatile protect bit 0
  output logic o_miso,                // Serial data out
  output logic o_miso_oe,             // Output enable, high drives
  output logic o_write_enable_latch,  // Enable latch state
  output logic o_write_busy_flag,     // Write cycle running
  output logic o_page_locked          // Page lock state
);
  typedef struct packed {
    phase_t phase;
    logic sclk_d;
    logic cs_d;
    logic [2:0] bitcnt;
    logic [7:0] shin;
    logic [7:0] shout;
    logic [7:0] opcode;
    logic addr_hi_done;
    logic [15:0] addr;
    logic [5:0] ptr;
    logic got_data;
    logic lock_bit;
    logic write_enable_latch;
    logic pend_lock;
    logic start;
    logic miso;
    logic miso_oe;
    logic [63:0] wmask;
  } core_t;

  core_t st_r;
  core_t st_nxt;
  spi_pins_t pins;
  spi_pins_t raw_pins;
  logic busy;
  logic done;
  logic lock_nv_r = 1'b0;  // Nonvolatile lock, kept over reset
  logic lock_nv_nxt;
  logic [7:0] page_mem [page_bytes];
  logic [7:0] wbuf [page_bytes];
  logic [7:0] lock_byte;
  logic prot_all;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;
  logic byte_done;
  logic [7:0] byte_in;

  // Raw pins gathered for the synchroniser
  assign raw_pins = '{cs_n: i_cs_n, sclk: i_sclk, mosi: i_mosi};

  pin_sync u_sync (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_pins(raw_pins),
    .o_pins(pins)
  );

  prog_timer #(.cycles(program_cycles)) u_timer (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_start(st_r.start),
    .o_busy(busy),
    .o_done(done)
  );

  // Edge detection on synchronised pins
  assign sclk_rise = pins.sclk && !st_r.sclk_d && !pins.cs_n;
  assign sclk_fall = !pins.sclk && st_r.sclk_d && !pins.cs_n;
  assign cs_rise = pins.cs_n && !st_r.cs_d;
  assign byte_done = sclk_rise && (st_r.bitcnt == 3'd7);
  assign byte_in = {st_r.shin[6:0], pins.mosi};
  // protect bits are stored levels, never reset here
  assign prot_all = i_block_protect_hi && i_block_protect_lo;
  assign lock_byte = {7'h0, lock_nv_r};

  // Protocol sequencing
  always_comb begin
    st_nxt = st_r;
    st_nxt.sclk_d = pins.sclk;
    st_nxt.cs_d = pins.cs_n;
    st_nxt.start = 1'b0;
    if (done) begin
      st_nxt.write_enable_latch = 1'b0;
      st_nxt.pend_lock = 1'b0;
    end
    // Deselect handling
    if (pins.cs_n) begin
      st_nxt.phase = st_cmd;
      st_nxt.bitcnt = 3'd0;
      st_nxt.addr_hi_done = 1'b0;
      st_nxt.miso_oe = 1'b0;
      st_nxt.miso = 1'b0;
    end else begin
      st_nxt.miso_oe = 1'b1;
    end
    // Frame end decisions
    if (cs_rise) begin
      if (st_r.phase == st_wr_data && st_r.bitcnt == 3'd0
          && st_r.got_data && !busy) begin
        if (st_r.write_enable_latch && !prot_all) begin
          if (!st_r.addr[page_sel_bit]) begin
            if (!lock_nv_r) begin
              st_nxt.start = 1'b1;
            end
          end else if (st_r.lock_bit) begin
            st_nxt.start = 1'b1;
            st_nxt.pend_lock = 1'b1;
          end
        end
      end
      if (st_r.phase == st_cmd && st_r.bitcnt == 3'd0 && st_r.got_data) begin
        if (st_r.opcode == op_write_enable) begin
          st_nxt.write_enable_latch = 1'b1;
        end else if (st_r.opcode == op_write_disable) begin
          st_nxt.write_enable_latch = 1'b0;
        end
      end
      // Byte mask kept until the commit strobe has used it
      st_nxt.got_data = 1'b0;
    end
    // Bit capture
    if (sclk_rise) begin
      st_nxt.shin = byte_in;
      st_nxt.bitcnt = st_r.bitcnt + 3'd1;
    end
    // Byte decode
    if (byte_done) begin
      unique case (st_r.phase)
        st_cmd: begin
          st_nxt.opcode = byte_in;
          st_nxt.got_data = 1'b1;
          if (byte_in == op_id_read || byte_in == op_id_program) begin
            st_nxt.phase = st_addr;
            st_nxt.got_data = 1'b0;
            st_nxt.wmask = '0;
          end else if (byte_in != op_write_enable
                       && byte_in != op_write_disable) begin
            st_nxt.phase = st_skip;
          end
        end
        st_addr: begin
          if (!st_r.addr_hi_done) begin
            st_nxt.addr[15:8] = byte_in;
            st_nxt.addr_hi_done = 1'b1;
          end else begin
            st_nxt.addr[7:0] = byte_in;
            st_nxt.ptr = byte_in[5:0];
            if (st_r.opcode == op_id_program) begin
              st_nxt.phase = st_wr_data;
            end else if (busy) begin
              st_nxt.phase = st_skip;
            end else if (st_r.addr[page_sel_bit]) begin
              st_nxt.phase = st_rd_lock;
              st_nxt.shout = lock_byte;
            end else begin
              st_nxt.phase = st_rd_id;
              st_nxt.shout = page_mem[byte_in[5:0]];
            end
          end
        end
        st_rd_id: begin
          st_nxt.ptr = st_r.ptr + 6'd1;
          st_nxt.shout = page_mem[6'(st_r.ptr + 6'd1)];
        end
        st_rd_lock: begin
          st_nxt.shout = lock_byte;
        end
        st_wr_data: begin
          st_nxt.got_data = 1'b1;
          st_nxt.lock_bit = byte_in[lock_data_bit];
          st_nxt.wmask[st_r.ptr] = 1'b1;
          st_nxt.ptr = st_r.ptr + 6'd1;
        end
        st_skip: begin
          st_nxt.phase = st_skip;
        end
      endcase
    end else if (sclk_rise && st_r.phase == st_wr_data) begin
      st_nxt.got_data = 1'b0;
    end
    // MSB first on falling clock
    if (sclk_fall && (st_r.phase == st_rd_id
                      || st_r.phase == st_rd_lock)) begin
      st_nxt.miso = st_r.shout[7];
      st_nxt.shout = {st_r.shout[6:0], 1'b0};
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r <= '{
        phase: st_cmd,
        sclk_d: 1'b0,
        cs_d: 1'b1,
        bitcnt: 3'd0,
        shin: 8'h00,
        shout: 8'h00,
        opcode: 8'h00,
        addr_hi_done: 1'b0,
        addr: 16'h0000,
        ptr: 6'h00,
        got_data: 1'b0,
        lock_bit: 1'b0,
        write_enable_latch: 1'b0,
        pend_lock: 1'b0,
        start: 1'b0,
        miso: 1'b0,
        miso_oe: 1'b0,
        wmask: 64'h0
      };
    end else begin
      st_r <= st_nxt;
    end
  end

  // Nonvolatile lock bit, set when a lock cycle completes
  // lock becomes permanent
  always_comb begin
    lock_nv_nxt = lock_nv_r;
    if (done && st_r.pend_lock) begin
      lock_nv_nxt = 1'b1;
    end
  end

  // No reset: the lock must survive a power-on reset
  always_ff @(posedge i_clk) begin
    lock_nv_r <= lock_nv_nxt;
  end

  // Byte capture buffer and page store
  genvar gi;
  for (gi = 0; gi < page_bytes; gi++) begin : g_page
    always_ff @(posedge i_clk) begin
      if (byte_done && st_r.phase == st_wr_data && st_r.ptr == 6'(gi)) begin
        wbuf[gi] <= byte_in;
      end
    end
    always_ff @(posedge i_clk) begin
      if (st_r.start && !st_r.pend_lock && st_r.wmask[gi]) begin
        page_mem[gi] <= wbuf[gi];
      end
    end
  end

  assign o_miso = st_r.miso;
  assign o_miso_oe = st_r.miso_oe;
  assign o_write_enable_latch = st_r.write_enable_latch;
  assign o_write_busy_flag = busy;
  assign o_page_locked = lock_nv_r;
endmodule

/* File: logic/id_page_pkg.sv */
// Function
// - ID read returns byte at six low address bits, MSB first.
// - ID page is 64 bytes; read may start anywhere.
// - Read keeps going; address advances after each byte.
// - Chip select rising ends read anytime; output released.
// - ID read ignored while write cycle runs.
// - ID write: opcode, address with select bit zero, data bytes.
// - Accepted ID write starts timed cycle at select release.
// - Writes to first three bytes overwrite the identity code.
// - Writes and lock dropped when busy, both protect bits, or no enable.
// - Status byte LSB is one when page is locked.
// - Status byte repeats while select stays low.
// - Lock status read rejected while write cycle runs.
// - Lock runs only when select rises on a byte boundary.
// - Valid lock starts the timed write cycle.
// - Completed lock makes the page read-only for good.
// - Reset clears enable latch and busy flag; device deselected.
// - Reset keeps nonvolatile protect and lock bits.
// - Serial output driven only while selected.
// - Read pair opcode 0x83, write pair 0x82, split by select bit.
// - Write enable must precede ID writes and lock.
package id_page_pkg;
  localparam logic [7:0] op_id_read = 8'h83;
  localparam logic [7:0] op_id_program = 8'h82;
  localparam logic [7:0] op_write_enable = 8'h06;
  localparam logic [7:0] op_write_disable = 8'h04;
  localparam int page_sel_bit = 10;
  localparam int lock_data_bit = 1;
  localparam int page_bytes = 64;
  localparam int clk_mhz = 40;
  localparam int self_timed_program_time_us = 4000;
  localparam int prog_cycles = self_timed_program_time_us * clk_mhz;
  localparam logic [7:0] id_reset_byte = 8'hff;

  typedef enum logic [2:0] {
    st_cmd, st_addr, st_rd_id, st_rd_lock, st_wr_data, st_skip
  } phase_t;

  // Serial pins as seen after synchronisers
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic mosi;
  } spi_pins_t;
endpackage

/* File: logic/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync
  import id_page_pkg::*;
(
  input wire logic i_clk,          // System clock
  input wire logic i_nrst,         // Async reset, active low
  input wire spi_pins_t i_pins,    // Raw pins
  output spi_pins_t o_pins         // Synchronised pins
);
  typedef struct packed {
    spi_pins_t s1;
    spi_pins_t s2;
  } sync_t;
  sync_t st_r;
  sync_t st_nxt;

  // Two-stage shift
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = i_pins;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r <= '{s1: '{cs_n: 1'b1, sclk: 1'b0, mosi: 1'b0},
                s2: '{cs_n: 1'b1, sclk: 1'b0, mosi: 1'b0}};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_pins = st_r.s2;
endmodule

/* File: logic/prog_timer.sv */
`timescale 1ns/1ps
module prog_timer
  import id_page_pkg::*;
#(
  parameter int cycles = prog_cycles
)(
  input wire logic i_clk,     // System clock
  input wire logic i_nrst,    // Async reset, active low
  input wire logic i_start,   // Start pulse
  output logic o_busy,        // Cycle running
  output logic o_done         // End pulse
);
  typedef struct packed {
    logic busy;
    logic [31:0] cnt;
  } tmr_t;
  tmr_t st_r;
  tmr_t st_nxt;

  // Count down the self-timed cycle
  always_comb begin
    st_nxt = st_r;
    if (i_start && !st_r.busy) begin
      st_nxt.busy = 1'b1;
      st_nxt.cnt = 32'(cycles - 1);
    end else if (st_r.busy) begin
      if (st_r.cnt == 32'h0) begin
        st_nxt.busy = 1'b0;
      end else begin
        st_nxt.cnt = st_r.cnt - 32'h1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_busy = st_r.busy;
  // Last busy cycle, so the caller clears its flags with busy
  assign o_done = st_r.busy && (st_r.cnt == 32'h0);
endmodule

/* File: verification/id_page_checker_assertions.sv */
`timescale 1ns/1ps
module id_page_checker
  import id_page_pkg::*;
#(
  parameter int program_cycles = prog_cycles
)(
  input wire logic i_clk,                // Clock
  input wire logic i_nrst,               // Reset, active low
  input wire logic i_cs_n,               // Chip select
  input wire logic i_block_protect_hi,   // Protect bit 1
  input wire logic i_block_protect_lo,   // Protect bit 0
  input wire logic o_miso_oe,            // Output enable
  input wire logic o_write_enable_latch, // Enable latch
  input wire logic o_write_busy_flag,    // Busy
  input wire logic o_page_locked         // Lock state
);
  int unsigned busy_cnt_r;
  // Length of the current busy stretch
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) busy_cnt_r <= 0;
    else busy_cnt_r <= o_write_busy_flag ? busy_cnt_r + 1 : 0;
  end
  a_reset_clears: assert property (@(posedge i_clk)
    !i_nrst |-> !o_write_busy_flag && !o_write_enable_latch && !o_miso_oe)
    else $error("outputs not cleared in reset");
  a_oe_needs_select: assert property (@(posedge i_clk)
    disable iff (!i_nrst) o_miso_oe |-> !$past(i_cs_n, 2) ||
    !$past(i_cs_n, 3) || !$past(i_cs_n, 4) || !$past(i_cs_n, 5))
    else $error("output driven while deselected");
  a_oe_release: assert property (@(posedge i_clk)
    disable iff (!i_nrst) i_cs_n [*6] |-> !o_miso_oe)
    else $error("output not released");
  a_busy_start: assert property (@(posedge i_clk)
    disable iff (!i_nrst) $rose(o_write_busy_flag) |-> i_cs_n &&
    $past(o_write_enable_latch) && !(i_block_protect_hi && i_block_protect_lo))
    else $error("write cycle started without cause");
  a_busy_length: assert property (@(posedge i_clk)
    disable iff (!i_nrst) $fell(o_write_busy_flag) |->
    busy_cnt_r + 1 >= program_cycles && busy_cnt_r <= program_cycles + 1)
    else $error("write cycle length wrong");
  a_busy_end_latch: assert property (@(posedge i_clk)
    disable iff (!i_nrst) $fell(o_write_busy_flag) |-> !o_write_enable_latch)
    else $error("enable latch kept after cycle");
  a_lock_sticky: assert property (@(posedge i_clk)
    disable iff (!i_nrst) o_page_locked |=> o_page_locked)
    else $error("lock state lost");
  a_lock_in_cycle: assert property (@(posedge i_clk)
    disable iff (!i_nrst) $rose(o_page_locked) |->
    $past(o_write_busy_flag) or ##[0:1] o_write_busy_flag)
    else $error("lock set outside write cycle");
endmodule

/* File: verification/spi_master_model.sv */
`timescale 1ns/1ps
module spi_master_model (
  input wire logic i_clk,     // System clock
  input wire logic i_miso,    // Slave data
  input wire logic i_miso_oe, // Slave drives line
  output logic o_cs_n,        // Chip select
  output logic o_sclk,        // Serial clock
  output logic o_mosi         // Serial data out
);
  logic line_r = 1'b0;
  logic seen;
  // Released line toggles, never holds a value
  assign seen = i_miso_oe ? i_miso : ~line_r;
  always @(posedge i_clk) line_r <= seen;
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_mosi = 1'b0;
  end
  task automatic sel();
    @(negedge i_clk) o_cs_n = 1'b0;
    repeat (4) @(negedge i_clk);
  endtask
  task automatic desel();
    repeat (4) @(negedge i_clk);
    o_cs_n = 1'b1;
    repeat (16) @(negedge i_clk);
  endtask
  // Mode 0, MSB first, 200 ns bit time
  task automatic xfer(input logic [7:0] tx, input int n,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < n; i++) begin
      @(negedge i_clk) o_mosi = tx[7-i];
      repeat (3) @(negedge i_clk);
      o_sclk = 1'b1;
      repeat (4) @(negedge i_clk);
      rx = {rx[6:0], seen};
      o_sclk = 1'b0;
    end
  endtask
endmodule

/* File: verification/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import id_page_pkg::*;
  localparam int cyc = 1200;
  typedef struct packed {
    logic [5:0] a;
    logic [7:0] d0;
    logic [7:0] d1;
  } row_t;
  logic clk = 1'b0;
  logic nrst = 1'b1;
  logic bp_hi = 1'b0;
  logic bp_lo = 1'b0;
  logic cs_n, sclk, mosi, miso, miso_oe, write_enable_latch, busy, locked;
  logic [7:0] rx;
  int failures = 0;
  int checks = 0;
  int ticks = 0;
  row_t rows [3] = '{'{6'h00, 8'h5a, 8'hc3}, '{6'h1f, 8'h01, 8'h80},
                     '{6'h3e, 8'ha5, 8'h7e}};
  always #12.5 clk = ~clk;
  id_page_slave #(.program_cycles(cyc)) dut (.i_clk(clk), .i_nrst(nrst),
    .i_cs_n(cs_n), .i_sclk(sclk), .i_mosi(mosi), .i_block_protect_hi(bp_hi),
    .i_block_protect_lo(bp_lo), .o_miso(miso), .o_miso_oe(miso_oe),
    .o_write_enable_latch(write_enable_latch), .o_write_busy_flag(busy),
    .o_page_locked(locked));
  spi_master_model m (.i_clk(clk), .i_miso(miso), .i_miso_oe(miso_oe),
    .o_cs_n(cs_n), .o_sclk(sclk), .o_mosi(mosi));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic hdr(input logic [7:0] op, input logic [15:0] ad);
    m.sel();
    m.xfer(op, 8, rx);
    m.xfer(ad[15:8], 8, rx);
    m.xfer(ad[7:0], 8, rx);
  endtask
  task automatic cmd1(input logic [7:0] op);
    m.sel();
    m.xfer(op, 8, rx);
    m.desel();
  endtask
  task automatic write_enable_cmd();
    cmd1(op_write_enable);
  endtask
  task automatic prog(input logic [5:0] a, input logic [7:0] d0,
                      input logic [7:0] d1);
    write_enable_cmd();
    hdr(op_id_program, {10'h000, a});
    m.xfer(d0, 8, rx);
    m.xfer(d1, 8, rx);
    m.desel();
  endtask
  task automatic rd(input logic [15:0] ad, input logic [7:0] e0,
                    input logic [7:0] e1);
    hdr(op_id_read, ad);
    m.xfer(8'h00, 8, rx);
    chk(rx, e0);
    m.xfer(8'h00, 8, rx);
    chk(rx, e1);
    m.desel();
  endtask
  // stay deselected until the cycle ends
  task automatic wait_idle();
    for (int k = 0; k < cyc + 200 && busy !== 1'b0; k++) @(negedge clk);
    chk({7'h0, busy}, 8'h00);
  endtask
  // lock data byte with bit 1 set
  task automatic lock(input int n);
    write_enable_cmd();
    hdr(op_id_program, 16'h0400);
    m.xfer(8'h02, n, rx);
    m.desel();
  endtask
  always @(posedge clk) begin
    ticks++;
    if (ticks == 60000) begin
      failures++;
      end_of_test();
    end
  end
  initial begin
    @(negedge clk) nrst = 1'b0;
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    chk({5'h0, write_enable_latch, busy, miso_oe}, 8'h00);
    foreach (rows[i]) begin
      prog(rows[i].a, rows[i].d0, rows[i].d1);
      chk({7'h0, busy}, 8'h01);
      wait_idle();
      chk({6'h0, write_enable_latch, busy}, 8'h00);
      rd({10'h000, rows[i].a}, rows[i].d0, rows[i].d1);
    end
    prog(6'h10, 8'h11, 8'h22);
    rd(16'h0010, 8'h00, 8'h00);
    rd(16'h0400, 8'h00, 8'h00);
    wait_idle();
    rd(16'h0010, 8'h11, 8'h22);
    hdr(op_id_program, 16'h0010);
    m.xfer(8'h77, 8, rx);
    m.desel();
    chk({7'h0, busy}, 8'h00);
    bp_hi = 1'b1;
    bp_lo = 1'b1;
    prog(6'h10, 8'h33, 8'h44);
    chk({7'h0, busy}, 8'h00);
    bp_hi = 1'b0;
    bp_lo = 1'b0;
    rd(16'h0400, 8'h00, 8'h00);
    lock(5);
    chk({6'h0, busy, locked}, 8'h00);
    lock(8);
    chk({7'h0, busy}, 8'h01);
    wait_idle();
    chk({7'h0, locked}, 8'h01);
    rd(16'h0400, 8'h01, 8'h01);
    prog(rows[0].a, 8'hee, 8'hee);
    wait_idle();
    rd({10'h000, rows[0].a}, rows[0].d0, rows[0].d1);
    cmd1(op_write_enable);
    chk({7'h0, write_enable_latch}, 8'h01);
    cmd1(op_write_disable);
    chk({7'h0, write_enable_latch}, 8'h00);
    cmd1(op_write_enable);
    @(negedge clk) nrst = 1'b0;
    repeat (4) @(negedge clk);
    chk({6'h0, write_enable_latch, busy}, 8'h00);
    nrst = 1'b1;
    chk({7'h0, locked}, 8'h01);
    rd(16'h0400, 8'h01, 8'h01);
    end_of_test();
  end
endmodule
bind id_page_slave id_page_checker #(.program_cycles(program_cycles)) chk_i (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_cs_n(i_cs_n),
  .i_block_protect_hi(i_block_protect_hi),
  .i_block_protect_lo(i_block_protect_lo), .o_miso_oe(o_miso_oe),
  .o_write_enable_latch(o_write_enable_latch),
  .o_write_busy_flag(o_write_busy_flag), .o_page_locked(o_page_locked));
